// ### shared/pin_mux_pkg.sv
/*
 * constants, field layouts and signal bundles for the pin output
 * source multiplexer; assumes one register clock and an 8-bit
 * register port with byte offsets.
 */
package pin_mux_pkg;

    // register offsets
    localparam logic [7:0] PIN6_CTL_OFFSET = 8'h16;
    localparam logic [7:0] PIN7_CTL_OFFSET = 8'h17;
    localparam logic [7:0] PIN_STATUS_OFFSET = 8'h1e;
    localparam logic [7:0] LEVEL_MODE_OFFSET = 8'h1f;

    // values after reset
    localparam logic [7:0] PIN_CTL_RESET = 8'h00;
    localparam logic [1:0] LEVEL_MODE_RESET = 2'h0;

    // field positions inside a control byte
    localparam int DRIVE_ON_BIT = 0;
    localparam int LEVEL_BIT = 1;
    localparam int ORIGIN_LSB = 2;
    localparam int CHOICE_LSB = 5;

    // origin codes
    localparam logic [2:0] ORIGIN_STATUS = 3'h4;
    localparam logic [2:0] ORIGIN_RESERVED = 3'h5;

    // choice codes, rx origin
    localparam logic [2:0] RX_LOCK = 3'h4;
    localparam logic [2:0] RX_PASS = 3'h5;
    localparam logic [2:0] RX_FRAME = 3'h6;
    localparam logic [2:0] RX_LINE = 3'h7;

    // choice codes, status origin
    localparam logic [2:0] ST_OR_LOCK = 3'h1;
    localparam logic [2:0] ST_AND_LOCK = 3'h2;
    localparam logic [2:0] ST_AND_PASS = 3'h3;
    localparam logic [2:0] ST_SYNC = 3'h4;

    // choice codes, tx origin
    localparam logic [2:0] TX_AND_PASS = 3'h0;
    localparam logic [2:0] TX_OR_PASS = 3'h1;
    localparam logic [2:0] TX_FRAME = 3'h2;
    localparam logic [2:0] TX_LINE = 3'h3;
    localparam logic [2:0] TX_SYNCED = 3'h4;
    localparam logic [2:0] TX_IRQ = 3'h5;

    // one control byte, msb first
    typedef struct packed {
        logic [2:0] choice;
        logic [2:0] origin;
        logic level;
        logic drive_on;
    } pin_ctl_t;

    // signals of one receive port
    typedef struct packed {
        logic [3:0] remote;
        logic lock;
        logic pass;
        logic frame_valid;
        logic line_valid;
    } rx_port_sig_t;

    // signals of one transmit port
    typedef struct packed {
        logic [3:0] rx_map;
        logic frame_valid;
        logic line_valid;
        logic synced;
        logic irq;
    } tx_port_sig_t;

    // and over the ports that the mask keeps, low when none is kept
    function automatic logic masked_and(input logic [3:0] bits, input logic [3:0] mask);
        masked_and = (|mask) & (&(bits | ~mask));
    endfunction

    // or over the ports that the mask keeps
    function automatic logic masked_or(input logic [3:0] bits, input logic [3:0] mask);
        masked_or = |(bits & mask);
    endfunction

endpackage

// ### hw/pin_source_select.sv
/*
 * combinational source picker for one general-purpose pin;
 * assumes all port signals are already on the register clock.
 */
`timescale 1ns/1ns
module pin_source_select (
    // control byte of this pin
    input wire pin_mux_pkg::pin_ctl_t ctl,
    // receive and transmit port signals
    input wire pin_mux_pkg::rx_port_sig_t [3:0] rx_ports,
    input wire pin_mux_pkg::tx_port_sig_t [1:0] tx_ports,
    input wire logic [3:0] rx_enabled,
    input wire logic frame_sync_pulse,
    // picked level
    output logic picked
);
    import pin_mux_pkg::*;

    // lock and pass gathered across ports
    logic [3:0] all_lock;
    logic [3:0] all_pass;

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            all_lock[i] = rx_ports[i].lock;
            all_pass[i] = rx_ports[i].pass;
        end
    end

    // the picker; reserved codes fall to low
    always_comb begin
        rx_port_sig_t rx;
        tx_port_sig_t tx;
        rx = rx_ports[ctl.origin[1:0]];
        tx = tx_ports[ctl.origin[0]];
        picked = 1'b0;
        if (!ctl.origin[2]) begin
            if (!ctl.choice[2]) begin
                picked = rx.remote[ctl.choice[1:0]];
            end else begin
                unique case (ctl.choice)
                    RX_LOCK: picked = rx.lock;
                    RX_PASS: picked = rx.pass;
                    RX_FRAME: picked = rx.frame_valid;
                    default: picked = rx.line_valid;
                endcase
            end
        end else if (ctl.origin == ORIGIN_STATUS) begin
            unique case (ctl.choice)
                ST_OR_LOCK: picked = masked_or(all_lock, rx_enabled);
                ST_AND_LOCK: picked = masked_and(all_lock, rx_enabled);
                ST_AND_PASS: picked = masked_and(all_pass, rx_enabled);
                ST_SYNC: picked = frame_sync_pulse;
                default: picked = 1'b0;
            endcase
        end else if (ctl.origin != ORIGIN_RESERVED) begin
            unique case (ctl.choice)
                TX_AND_PASS: picked = masked_and(all_pass, tx.rx_map);
                TX_OR_PASS: picked = masked_or(all_pass, tx.rx_map);
                TX_FRAME: picked = tx.frame_valid;
                TX_LINE: picked = tx.line_valid;
                TX_SYNCED: picked = tx.synced;
                TX_IRQ: picked = tx.irq;
                default: picked = 1'b0;
            endcase
        end
    end
endmodule // pin_source_select

// ### hw/pin_output_source_mux.sv
/*
 * output control for two general-purpose pins: two control
 * registers, a local-level mode register, a status register and
 * registered pin drive; assumes a single-cycle register port on the
 * same clock and port signals that are synchronous to core_clk.
 */
// Strobed register access was left to the implementer.
`timescale 1ns/1ns
module pin_output_source_mux (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // receive port signals
    input wire pin_mux_pkg::rx_port_sig_t [3:0] rx_ports,
    input wire logic [3:0] rx_enabled,
    input wire logic frame_sync_pulse,
    // transmit port signals
    input wire pin_mux_pkg::tx_port_sig_t [1:0] tx_ports,
    // pin six drive
    output logic pin6_out,
    output logic pin6_oe,
    // pin seven drive
    output logic pin7_out,
    output logic pin7_oe
);
    import pin_mux_pkg::*;

    // control registers for both pins
    pin_ctl_t pin6_output_control;
    pin_ctl_t pin7_output_control;
    pin_ctl_t next_pin6_ctl;
    pin_ctl_t next_pin7_ctl;

    // per pin: 1 drives the register level instead of the picked one
    logic [1:0] level_mode;
    logic [1:0] next_level_mode;

    // read data, held one cycle after the strobe only
    logic [7:0] next_rdata;

    // levels picked from the port signals
    logic pin6_picked;
    logic pin7_picked;

    // next pin drive values
    logic next_pin6_out;
    logic next_pin6_oe;
    logic next_pin7_out;
    logic next_pin7_oe;

    // register writes
    always_comb begin
        next_pin6_ctl = pin6_output_control;
        next_pin7_ctl = pin7_output_control;
        next_level_mode = level_mode;
        if (reg_wr) begin
            unique case (reg_addr)
                PIN6_CTL_OFFSET: next_pin6_ctl = pin_ctl_t'(reg_wdata);
                PIN7_CTL_OFFSET: next_pin7_ctl = pin_ctl_t'(reg_wdata);
                LEVEL_MODE_OFFSET: next_level_mode = reg_wdata[1:0];
                // unmapped writes are dropped silently
                default: next_level_mode = level_mode;
            endcase
        end
    end

    // register storage
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin6_output_control <= pin_ctl_t'(PIN_CTL_RESET);
            pin7_output_control <= pin_ctl_t'(PIN_CTL_RESET);
            level_mode <= LEVEL_MODE_RESET;
        end else begin
            pin6_output_control <= next_pin6_ctl;
            pin7_output_control <= next_pin7_ctl;
            level_mode <= next_level_mode;
        end
    end

    // register reads; data stands only in the cycle after the strobe
    always_comb begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            unique case (reg_addr)
                PIN6_CTL_OFFSET: next_rdata = pin6_output_control;
                PIN7_CTL_OFFSET: next_rdata = pin7_output_control;
                LEVEL_MODE_OFFSET: next_rdata = {6'h00, level_mode};
                // live drive state of both pins
                PIN_STATUS_OFFSET: next_rdata = {4'h0, pin7_oe, pin7_out, pin6_oe, pin6_out};
                // unmapped reads answer zero
                default: next_rdata = 8'h00;
            endcase
        end
    end

    // read data register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // one picker per pin; the same decode serves both
    pin_source_select pick6 (
        .ctl(pin6_output_control),
        .rx_ports(rx_ports),
        .tx_ports(tx_ports),
        .rx_enabled(rx_enabled),
        .frame_sync_pulse(frame_sync_pulse),
        .picked(pin6_picked)
    );

    pin_source_select pick7 (
        .ctl(pin7_output_control),
        .rx_ports(rx_ports),
        .tx_ports(tx_ports),
        .rx_enabled(rx_enabled),
        .frame_sync_pulse(frame_sync_pulse),
        .picked(pin7_picked)
    );

    // pin drive; the level is low whenever the driver is off so a
    // disabled pin never shows a stale picked value to the pad
    always_comb begin
        next_pin6_oe = pin6_output_control.drive_on;
        next_pin7_oe = pin7_output_control.drive_on;
        next_pin6_out = pin6_output_control.drive_on &
            (level_mode[0] ? pin6_output_control.level : pin6_picked);
        next_pin7_out = pin7_output_control.drive_on &
            (level_mode[1] ? pin7_output_control.level : pin7_picked);
    end

    // drive registers; one cycle of latency buys glitch-free pins
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            pin6_out <= 1'b0;
            pin6_oe <= 1'b0;
            pin7_out <= 1'b0;
            pin7_oe <= 1'b0;
        end else begin
            pin6_out <= next_pin6_out;
            pin6_oe <= next_pin6_oe;
            pin7_out <= next_pin7_out;
            pin7_oe <= next_pin7_oe;
        end
    end

    // checks on register access and pin drive
    default clocking chk_cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);

    // helper: picked rx remote level for pin six
    logic rx6_remote;
    assign rx6_remote = rx_ports[pin6_output_control.origin[1:0]]
        .remote[pin6_output_control.choice[1:0]];

    // helpers for the checks below; short names keep the checks readable
    pin_ctl_t ctl6;
    rx_port_sig_t rx6_sel;
    tx_port_sig_t tx6_sel;
    logic [3:0] lock_all;
    logic [3:0] pass_all;
    logic pick6_mode;
    logic rx6_origin;
    logic tx6_origin;
    assign ctl6 = pin6_output_control;
    assign rx6_sel = rx_ports[ctl6.origin[1:0]];
    assign tx6_sel = tx_ports[ctl6.origin[0]];
    assign lock_all = {rx_ports[3].lock, rx_ports[2].lock, rx_ports[1].lock, rx_ports[0].lock};
    assign pass_all = {rx_ports[3].pass, rx_ports[2].pass, rx_ports[1].pass, rx_ports[0].pass};
    // the picked path only reaches the pin with the driver on and no override
    assign pick6_mode = ctl6.drive_on && !level_mode[0];
    assign rx6_origin = pick6_mode && !ctl6.origin[2];
    assign tx6_origin = pick6_mode && ctl6.origin[2:1] == 2'h3;

    // a write to the first control byte lands next cycle
    chk_pin6_write:
        assert property (reg_wr && reg_addr == PIN6_CTL_OFFSET
            |=> pin6_output_control == $past(reg_wdata))
        else $error("pin six control write lost");

    // a write to the second control byte lands next cycle
    chk_pin7_write:
        assert property (reg_wr && reg_addr == PIN7_CTL_OFFSET
            |=> pin7_output_control == $past(reg_wdata))
        else $error("pin seven control write lost");

    // a read of the second control byte returns it exactly one cycle later
    chk_read_pin7:
        assert property (reg_rd && reg_addr == PIN7_CTL_OFFSET
            |=> reg_rdata == $past(pin7_output_control))
        else $error("pin seven readback wrong");

    // driver follows the enable bit after two edges of a write
    chk_drive_enable:
        assert property (reg_wr && reg_addr == PIN6_CTL_OFFSET
            ##1 !reg_wr |=> pin6_oe == pin6_output_control.drive_on)
        else $error("pin six enable not applied");

    // local level mode drives the stored level bit
    chk_local_level:
        assert property (level_mode[1] && pin7_output_control.drive_on
            |=> pin7_out == $past(pin7_output_control.level))
        else $error("pin seven local level wrong");

    // reserved origin drives low unless local level mode is set for pin six
    chk_reserved_low:
        assert property (!level_mode[0]
            && pin6_output_control.origin == ORIGIN_RESERVED |=> !pin6_out)
        else $error("reserved origin not low");

    // rx origin with low choices forwards the remote pin
    chk_rx_remote:
        assert property (!level_mode[0] && pin6_output_control.drive_on
            && !pin6_output_control.origin[2] && !pin6_output_control.choice[2]
            |=> pin6_out == $past(rx6_remote))
        else $error("remote pin not forwarded");

    // status origin choice four follows the frame sync
    chk_status_sync:
        assert property (!level_mode[0] && pin6_output_control.drive_on
            && pin6_output_control.origin == ORIGIN_STATUS
            && pin6_output_control.choice == ST_SYNC
            |=> pin6_out == $past(frame_sync_pulse))
        else $error("frame sync not on pin");

    // tx origin choice five carries that port's interrupt
    chk_tx_irq:
        assert property (!level_mode[0] && pin6_output_control.drive_on
            && pin6_output_control.origin[2:1] == 2'h3
            && pin6_output_control.choice == TX_IRQ
            |=> pin6_out == $past(tx_ports[pin6_output_control.origin[0]].irq))
        else $error("tx interrupt not on pin");

    // rx origin choice four carries the port lock
    chk_rx_lock:
        assert property (rx6_origin && ctl6.choice == RX_LOCK
            |=> pin6_out == $past(rx6_sel.lock))
        else $error("rx lock not on pin");

    // rx origin choice five carries the port pass
    chk_rx_pass:
        assert property (rx6_origin && ctl6.choice == RX_PASS
            |=> pin6_out == $past(rx6_sel.pass))
        else $error("rx pass not on pin");

    // rx origin choice six carries frame valid
    chk_rx_frame:
        assert property (rx6_origin && ctl6.choice == RX_FRAME
            |=> pin6_out == $past(rx6_sel.frame_valid))
        else $error("rx frame valid not on pin");

    // rx origin choice seven carries line valid
    chk_rx_line:
        assert property (rx6_origin && ctl6.choice == RX_LINE
            |=> pin6_out == $past(rx6_sel.line_valid))
        else $error("rx line valid not on pin");

    // status origin: or of lock over enabled ports
    chk_status_or:
        assert property (pick6_mode && ctl6.origin == ORIGIN_STATUS && ctl6.choice == ST_OR_LOCK
            |=> pin6_out == $past(|(lock_all & rx_enabled)))
        else $error("status lock or wrong");

    // status origin: and of lock, low for an empty mask
    chk_status_and:
        assert property (pick6_mode && ctl6.origin == ORIGIN_STATUS && ctl6.choice == ST_AND_LOCK
            |=> pin6_out == $past(rx_enabled != 4'h0 && (lock_all & rx_enabled) == rx_enabled))
        else $error("status lock and wrong");

    // status origin: and of pass, low for an empty mask
    chk_status_pass:
        assert property (pick6_mode && ctl6.origin == ORIGIN_STATUS && ctl6.choice == ST_AND_PASS
            |=> pin6_out == $past(rx_enabled != 4'h0 && (pass_all & rx_enabled) == rx_enabled))
        else $error("status pass and wrong");

    // tx origin: and of pass over the mapped rx ports
    chk_tx_and_pass:
        assert property (tx6_origin && ctl6.choice == TX_AND_PASS
            |=> pin6_out == $past(tx6_sel.rx_map != 4'h0
                && (pass_all & tx6_sel.rx_map) == tx6_sel.rx_map))
        else $error("tx pass and wrong");

    // tx origin: or of pass over the mapped rx ports
    chk_tx_or_pass:
        assert property (tx6_origin && ctl6.choice == TX_OR_PASS
            |=> pin6_out == $past(|(pass_all & tx6_sel.rx_map)))
        else $error("tx pass or wrong");

    // tx origin: frame valid while a frame goes out
    chk_tx_frame:
        assert property (tx6_origin && ctl6.choice == TX_FRAME
            |=> pin6_out == $past(tx6_sel.frame_valid))
        else $error("tx frame valid not on pin");

    // tx origin: line valid while a line goes out
    chk_tx_line:
        assert property (tx6_origin && ctl6.choice == TX_LINE
            |=> pin6_out == $past(tx6_sel.line_valid))
        else $error("tx line valid not on pin");

    // tx origin: multi-port synchronised flag
    chk_tx_synced:
        assert property (tx6_origin && ctl6.choice == TX_SYNCED
            |=> pin6_out == $past(tx6_sel.synced))
        else $error("tx synced not on pin");

    // reserved status choices above four stay low
    chk_status_reserved:
        assert property (!level_mode[0] && ctl6.origin == ORIGIN_STATUS && ctl6.choice > ST_SYNC
            |=> !pin6_out)
        else $error("reserved status choice not low");

    // a disabled driver never shows a level
    chk_driver_off:
        assert property (!ctl6.drive_on |=> !pin6_oe && !pin6_out)
        else $error("disabled pin six still driven");

    // read data is zero outside the cycle after a read
    chk_read_idle:
        assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not cleared");

    // a read of the first control byte returns it one cycle later
    chk_pin6_read:
        assert property (reg_rd && reg_addr == PIN6_CTL_OFFSET
            |=> reg_rdata == $past(pin6_output_control))
        else $error("pin six readback wrong");

    // scenarios worth seeing
    cov_remote_forward: cover property (pin6_oe && !pin6_output_control.origin[2]
        && pin6_out ##1 !pin6_out);
    cov_tx_pass: cover property (pin7_oe
        && pin7_output_control.origin[2:1] == 2'h3 && pin7_out);
    cov_back_to_back: cover property (reg_wr ##1 reg_rd ##1 reg_wr);
    cov_status_sync: cover property (pin6_oe && ctl6.origin == ORIGIN_STATUS
        && ctl6.choice == ST_SYNC && pin6_out);
    cov_local_level: cover property (level_mode[1] && pin7_oe && pin7_out);
endmodule // pin_output_source_mux

// ### verification/pin_output_source_mux_tb_top.sv
/*
 * self-checking bench for the pin output source multiplexer: a table of
 * port patterns swept over every origin and choice code of both pins,
 * then hand tests for latency, local level, status, unmapped access and
 * a second reset. assumes the package and design files are compiled
 * first; the bench drives every port itself.
 */
`timescale 1ns/1ns
module pin_output_source_mux_tb_top;
    import pin_mux_pkg::*;

    // one table row: port pattern applied during a full code sweep
    typedef struct packed {
        logic [31:0] rx;
        logic [15:0] tx;
        logic [3:0] en;
        logic fs;
    } row_t;

    // clock, reset and register port
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    // port side stimulus
    rx_port_sig_t [3:0] rx_ports = '0;
    tx_port_sig_t [1:0] tx_ports = '0;
    logic [3:0] rx_enabled = 4'h0;
    logic frame_sync_pulse = 1'b0;
    // pin drive
    logic pin6_out;
    logic pin6_oe;
    logic pin7_out;
    logic pin7_oe;
    // bookkeeping
    int n_errors = 0;
    int tests_run = 0;
    logic [7:0] c6;
    logic [7:0] c7;
    // expected picked levels of the current sweep step
    logic e6;
    logic e7;
    // row 2 has empty masks, so all three and-reductions must read low
    row_t rows [3] = '{
        '{32'h198f55aa, 16'h956a, 4'hd, 1'b1},
        '{32'he670aa55, 16'h6a95, 4'h2, 1'b0},
        '{32'hfcfcfcfc, 16'h0f0f, 4'h0, 1'b1}
    };

    pin_output_source_mux dut_u (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_ports(rx_ports),
        .rx_enabled(rx_enabled), .frame_sync_pulse(frame_sync_pulse), .tx_ports(tx_ports),
        .pin6_out(pin6_out), .pin6_oe(pin6_oe), .pin7_out(pin7_out), .pin7_oe(pin7_oe)
    );

    // free-running 125 MHz clock
    always #4 core_clk = ~core_clk;

    // reference pick, written apart from the design's helpers
    function automatic logic ref_pick(input logic [7:0] c, input rx_port_sig_t [3:0] rx,
                                      input tx_port_sig_t [1:0] tx, input logic [3:0] en,
                                      input logic fs);
        logic [3:0] lk;
        logic [3:0] ps;
        logic [3:0] m;
        rx_port_sig_t r;
        tx_port_sig_t t;
        for (int i = 0; i < 4; i++) begin
            lk[i] = rx[i].lock;
            ps[i] = rx[i].pass;
        end
        ref_pick = 1'b0;
        if (!c[4]) begin
            r = rx[c[3:2]];
            case (c[7:5])
                3'h4: ref_pick = r.lock;
                3'h5: ref_pick = r.pass;
                3'h6: ref_pick = r.frame_valid;
                3'h7: ref_pick = r.line_valid;
                default: ref_pick = r.remote[c[6:5]];
            endcase
        end else if (c[4:2] == 3'h4) begin
            case (c[7:5])
                3'h1: ref_pick = |(lk & en);
                3'h2: ref_pick = (en != 4'h0) && ((lk & en) == en);
                3'h3: ref_pick = (en != 4'h0) && ((ps & en) == en);
                3'h4: ref_pick = fs;
                default: ref_pick = 1'b0;
            endcase
        end else if (c[4:3] == 2'b11) begin
            t = tx[c[2]];
            m = t.rx_map;
            case (c[7:5])
                3'h0: ref_pick = (m != 4'h0) && ((ps & m) == m);
                3'h1: ref_pick = |(ps & m);
                3'h2: ref_pick = t.frame_valid;
                3'h3: ref_pick = t.line_valid;
                3'h4: ref_pick = t.synced;
                3'h5: ref_pick = t.irq;
                default: ref_pick = 1'b0;
            endcase
        end
    endfunction

    // compare a single pin level
    task automatic chk_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // compare a register byte
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // checks run just after the edge so the driver never leaves the edge
    task automatic byte_later(input logic [7:0] e);
        fork
            begin
                #1;
                chk_byte(reg_rdata, e);
            end
        join_none
    endtask

    task automatic pin6_later(input logic o, input logic e);
        fork
            begin
                #1;
                chk_bit(pin6_out, o);
                chk_bit(pin6_oe, e);
            end
        join_none
    endtask

    task automatic pin7_later(input logic o, input logic e);
        fork
            begin
                #1;
                chk_bit(pin7_out, o);
                chk_bit(pin7_oe, e);
            end
        join_none
    endtask

    // strobes stay up between back-to-back calls; idle lowers them
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        @(posedge core_clk);
        byte_later(e);
    endtask

    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask

    // single exit point for the run
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog sized at about five times the expected run
    initial begin
        repeat (3000) @(posedge core_clk);
        n_errors++;
        tally_and_finish();
    end

    initial begin
        repeat (3) @(posedge core_clk);
        pin6_later(1'b0, 1'b0);
        byte_later(8'h00);
        rst_n <= 1'b1;
        // every code on both pins, pin6 with its level bit set but unused
        for (int r = 0; r < 3; r++) begin
            rx_ports <= rows[r].rx;
            tx_ports <= rows[r].tx;
            rx_enabled <= rows[r].en;
            frame_sync_pulse <= rows[r].fs;
            for (int k = 0; k < 64; k++) begin
                c6 = {k[5:0], 2'b11};
                c7 = {6'(63 - k), 2'b01};
                wr(PIN6_CTL_OFFSET, c6);
                wr(PIN7_CTL_OFFSET, c7);
                idle(1);
                e6 = ref_pick(c6, rows[r].rx, rows[r].tx, rows[r].en, rows[r].fs);
                e7 = ref_pick(c7, rows[r].rx, rows[r].tx, rows[r].en, rows[r].fs);
                pin6_later(e6, 1'b1);
                pin7_later(e7, 1'b1);
            end
        end
        // one-cycle path from a remote pin to the output
        rx_ports <= rows[0].rx;
        wr(PIN6_CTL_OFFSET, 8'h69);
        idle(1);
        pin6_later(1'b1, 1'b1);
        rx_ports[2].remote[3] <= 1'b0;
        @(posedge core_clk);
        pin6_later(1'b0, 1'b1);
        // local level drive and driver enable
        wr(LEVEL_MODE_OFFSET, 8'h03);
        wr(PIN6_CTL_OFFSET, 8'h03);
        wr(PIN7_CTL_OFFSET, 8'h01);
        idle(1);
        pin6_later(1'b1, 1'b1);
        pin7_later(1'b0, 1'b1);
        wr(PIN6_CTL_OFFSET, 8'h02);
        wr(PIN7_CTL_OFFSET, 8'h03);
        idle(1);
        pin6_later(1'b0, 1'b0);
        pin7_later(1'b1, 1'b1);
        // status is read-only, unmapped places read zero, reads back to back
        rd(PIN_STATUS_OFFSET, 8'h0c);
        wr(PIN_STATUS_OFFSET, 8'hff);
        wr(8'h20, 8'hff);
        rd(PIN_STATUS_OFFSET, 8'h0c);
        rd(8'h20, 8'h00);
        rd(PIN6_CTL_OFFSET, 8'h02);
        rd(PIN7_CTL_OFFSET, 8'h03);
        rd(LEVEL_MODE_OFFSET, 8'h03);
        idle(1);
        byte_later(8'h00);
        // reset in mid-run clears controls and pins at once
        rst_n <= 1'b0;
        @(posedge core_clk);
        pin7_later(1'b0, 1'b0);
        pin6_later(1'b0, 1'b0);
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(PIN6_CTL_OFFSET, 8'h00);
        rd(PIN7_CTL_OFFSET, 8'h00);
        rd(LEVEL_MODE_OFFSET, 8'h00);
        idle(2);
        pin6_later(1'b0, 1'b0);
        pin7_later(1'b0, 1'b0);
        idle(2);
        tally_and_finish();
    end

endmodule // pin_output_source_mux_tb_top
